// ===== verilog/ext_op_pkg.sv
// Purpose: shared constants and types of the extended-op decode/execute block
// Assumes: 8-bit core, 16-bit instruction words, four clock phases per instruction cycle
// Notes:   every opcode and phase code, and the enable, pointer and pc reset values, are named here once
package ext_op_pkg;

  localparam int          PTR_W       = 12;
  localparam int          PC_W        = 21;
  localparam int          NUM_PTR     = 3;
  localparam int          NUM_EXT_OPS = 8;

  // opcode high bytes and fixed words
  localparam logic [7:0]  OPC_PTR_ADD = 8'he8;
  localparam logic [7:0]  OPC_PTR_SUB = 8'he9;
  localparam logic [7:0]  OPC_PUSH    = 8'hea;
  localparam logic [7:0]  OPC_MOVE    = 8'heb;
  localparam logic [15:0] OPC_CALL_WK = 16'h0014;
  localparam logic [3:0]  OPC_SECOND  = 4'hf;

  // selector value naming the stack pointer, and its pointer index
  localparam logic [1:0]  SEL_STACK   = 2'h3;
  localparam logic [1:0]  STACK_IDX   = 2'h2;

  // highest file address remapped to stack-relative access
  localparam logic [7:0]  INDEX_LIMIT = 8'h5f;

  // quarter-cycle phase codes
  localparam logic [1:0]  Q1          = 2'h0;
  localparam logic [1:0]  Q2          = 2'h1;
  localparam logic [1:0]  Q3          = 2'h2;
  localparam logic [1:0]  Q4          = 2'h3;

  // reset values
  localparam logic              ENABLE_RESET = 1'b1;
  localparam logic [PTR_W-1:0]  PTR_RESET    = 12'h000;
  localparam logic [PC_W-1:0]   PC_RESET     = 21'h000000;

  typedef enum logic [3:0]
  {
    OP_NONE          = 4'h0,
    OP_PTR_ADD       = 4'h1,
    OP_PTR_SUB       = 4'h2,
    OP_STACK_ADD_RET = 4'h3,
    OP_STACK_SUB_RET = 4'h4,
    OP_CALL_WK       = 4'h5,
    OP_PUSH          = 4'h6,
    OP_MOVE_ABS      = 4'h7,
    OP_MOVE_IDX      = 4'h8
  } op_t;

  typedef enum logic [2:0]
  {
    ST_FIRST = 3'h1,
    ST_IDLE2 = 3'h2,
    ST_WORD2 = 3'h4
  } state_t;

endpackage : ext_op_pkg

// ===== verilog/ext_dec_if.sv
// Purpose: carries decoded fields from the decoder to the executer
// Assumes: decoder is purely combinational
// Notes:   fields are meaningful only in the phase the word is presented
interface ext_dec_if;
  ext_op_pkg::op_t op;
  logic [7:0]      lit;   // operand byte; selector and offsets are slices of it

  modport dec (output op, output lit);
  modport exe (input op, input lit);
endinterface : ext_dec_if

// ===== verilog/ext_op_decoder.sv
// Purpose: classify one instruction word into an extended operation
// Assumes: word is stable while presented
// Notes:   disabled extension yields no operation at all
module ext_op_decoder
(
  input  wire logic [15:0] i_instr_word,
  input  wire logic        i_ext_enable,
  ext_dec_if.dec           d
);

  // opcode classification, the eight extra instructions
  always_comb
  begin
    d.op   = ext_op_pkg::OP_NONE;
    d.lit  = i_instr_word[7:0];
    if (i_ext_enable)
    begin
      case (i_instr_word[15:8])
        ext_op_pkg::OPC_PTR_ADD:
          d.op = (i_instr_word[7:6] == ext_op_pkg::SEL_STACK) ?
                 ext_op_pkg::OP_STACK_ADD_RET : ext_op_pkg::OP_PTR_ADD;
        ext_op_pkg::OPC_PTR_SUB:
          d.op = (i_instr_word[7:6] == ext_op_pkg::SEL_STACK) ?
                 ext_op_pkg::OP_STACK_SUB_RET : ext_op_pkg::OP_PTR_SUB;
        ext_op_pkg::OPC_PUSH:
          d.op = ext_op_pkg::OP_PUSH;
        ext_op_pkg::OPC_MOVE:
          d.op = i_instr_word[7] ? ext_op_pkg::OP_MOVE_IDX : ext_op_pkg::OP_MOVE_ABS;
        default:
          // call via working register; a lone 1111 word stays a no-op
          if (i_instr_word == ext_op_pkg::OPC_CALL_WK)
            d.op = ext_op_pkg::OP_CALL_WK;
      endcase
    end
  end

endmodule : ext_op_decoder

// ===== verilog/ext_op_exec.sv
// Purpose: execute the extended instructions on the core's four-phase cycle
// Assumes: core presents a word in Q1 with i_instr_valid; memory read data same cycle
// Notes:   block owns the three indirect pointers; core owns pc and return stack

module ext_op_exec
#(
  parameter int PTR_W = ext_op_pkg::PTR_W,
  parameter int PC_W  = ext_op_pkg::PC_W
)
(
  input  wire logic                 i_clock,
  input  wire logic                 i_arst_n,
  input  wire logic                 i_ext_enable_cfg,
  input  wire logic [15:0]          i_instr_word,
  input  wire logic                 i_instr_valid,
  input  wire logic [7:0]           i_working_register,
  input  wire logic [7:0]           i_pc_high_latch,
  input  wire logic [4:0]           i_pc_upper_latch,
  input  wire logic [PC_W-1:0]      i_return_stack_top,
  input  wire logic [7:0]           i_mem_rdata,
  input  wire logic                 i_std_access_bit,
  input  wire logic [7:0]           i_std_file_addr,
  output logic [1:0]                o_q_phase,
  output logic                      o_stall,
  output logic                      o_ext_enabled,
  output logic [2:0][PTR_W-1:0]     o_indirect_pointer,
  output logic                      o_mem_re,
  output logic [PTR_W-1:0]          o_mem_raddr,
  output logic                      o_mem_we,
  output logic [PTR_W-1:0]          o_mem_waddr,
  output logic [7:0]                o_mem_wdata,
  output logic                      o_pc_load,
  output logic [PC_W-1:0]           o_pc_value,
  output logic                      o_push_pc,
  output logic                      o_use_indexed,
  output logic [PTR_W-1:0]          o_indexed_addr
);

  logic [1:0]                q_r;
  logic                      en_r;
  logic                      caught_r;
  ext_op_pkg::state_t        state_r;
  ext_op_pkg::op_t           op_r;
  logic [15:0]               ir_r;
  logic [15:0]               ir2_r;
  logic [7:0]                lit_r;
  logic [7:0]                move_data_r;
  logic [PTR_W-1:0]          sum_r;
  logic [PTR_W-1:0]          sum_nxt;
  logic [1:0]                wsel_r;
  logic [1:0]                wsel_nxt;
  logic                      wr_ptr_r;
  logic                      wr_ptr_nxt;
  logic [PTR_W-1:0]          ptr_r [ext_op_pkg::NUM_PTR];
  logic                      first;
  logic                      is_move;
  logic                      is_ret;

  ext_dec_if u_dec_if ();

  ext_op_decoder u_dec
  (
    .i_instr_word (i_instr_word),
    .i_ext_enable (en_r),
    .d            (u_dec_if)
  );

  assign first   = (state_r == ext_op_pkg::ST_FIRST);
  assign is_move = (op_r == ext_op_pkg::OP_MOVE_ABS) || (op_r == ext_op_pkg::OP_MOVE_IDX);
  assign is_ret  = (op_r == ext_op_pkg::OP_STACK_ADD_RET) ||
                   (op_r == ext_op_pkg::OP_STACK_SUB_RET);

  // free-running quarter-cycle counter
  always_ff @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n)
      q_r <= ext_op_pkg::Q1;
    else
      q_r <= q_r + 2'h1;

  always_ff @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n)
    begin
      en_r     <= ext_op_pkg::ENABLE_RESET;
      caught_r <= 1'b0;
    end
    else if (!caught_r)
    begin
      en_r     <= i_ext_enable_cfg;
      caught_r <= 1'b1;
    end

  // decode latched at end of Q1, literal at end of Q2
  always_ff @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n)
    begin
      op_r  <= ext_op_pkg::OP_NONE;
      ir_r  <= 16'h0000;
      ir2_r <= 16'h0000;
      lit_r <= 8'h00;
    end
    else if (q_r == ext_op_pkg::Q1)
    begin
      if (first && i_instr_valid)
      begin
        op_r <= u_dec_if.op;
        ir_r <= {i_instr_word[15:8], u_dec_if.lit};
      end
      else if (state_r == ext_op_pkg::ST_WORD2)
        ir2_r <= i_instr_word;   // second word consumed, never decoded
      else
        op_r <= ext_op_pkg::OP_NONE;   // idle second cycle
    end
    else if (q_r == ext_op_pkg::Q2)
      lit_r <= (op_r == ext_op_pkg::OP_PUSH) ? ir_r[7:0] : {2'h0, ir_r[5:0]};

  // two-cycle ops hold off the next fetch for one cycle
  always_ff @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n)
      state_r <= ext_op_pkg::ST_FIRST;
    else if (q_r == ext_op_pkg::Q4)
    begin
      case (state_r)
        ext_op_pkg::ST_FIRST:
          if (is_move)
            state_r <= ext_op_pkg::ST_WORD2;
          else if (is_ret || op_r == ext_op_pkg::OP_CALL_WK)
            state_r <= ext_op_pkg::ST_IDLE2;
        default:
          state_r <= ext_op_pkg::ST_FIRST;
      endcase
    end

  // Q3 arithmetic on the selected pointer; no status flags exist here
  always_comb
  begin
    sum_nxt    = ptr_r[ext_op_pkg::STACK_IDX];
    wsel_nxt   = ext_op_pkg::STACK_IDX;
    wr_ptr_nxt = first;
    case (op_r)
      ext_op_pkg::OP_PTR_ADD:
      begin
        sum_nxt  = ptr_r[ir_r[7:6]] + {4'h0, lit_r};
        wsel_nxt = ir_r[7:6];
      end
      ext_op_pkg::OP_PTR_SUB:
      begin
        sum_nxt  = ptr_r[ir_r[7:6]] - {4'h0, lit_r};
        wsel_nxt = ir_r[7:6];
      end
      ext_op_pkg::OP_STACK_ADD_RET:
        sum_nxt = ptr_r[ext_op_pkg::STACK_IDX] + {4'h0, lit_r};
      ext_op_pkg::OP_STACK_SUB_RET:
        sum_nxt = ptr_r[ext_op_pkg::STACK_IDX] - {4'h0, lit_r};
      ext_op_pkg::OP_PUSH:
        sum_nxt = ptr_r[ext_op_pkg::STACK_IDX] - 12'h001;
      default:
        wr_ptr_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n)
    begin
      sum_r    <= ext_op_pkg::PTR_RESET;
      wsel_r   <= 2'h0;
      wr_ptr_r <= 1'b0;
    end
    else if (q_r == ext_op_pkg::Q3)
    begin
      sum_r    <= sum_nxt;
      wsel_r   <= wsel_nxt;
      wr_ptr_r <= wr_ptr_nxt;
    end

  // pointer written at end of Q4, one register per pointer
  for (genvar g = 0; g < ext_op_pkg::NUM_PTR; g++)
  begin : g_ptr
    always_ff @(posedge i_clock or negedge i_arst_n)
      if (!i_arst_n)
        ptr_r[g] <= ext_op_pkg::PTR_RESET;
      else if (q_r == ext_op_pkg::Q4 && wr_ptr_r && wsel_r == 2'(g))
        ptr_r[g] <= sum_r;
    assign o_indirect_pointer[g] = ptr_r[g];
  end

  // source read in Q3 of first cycle, data kept for second
  always_ff @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n)
    begin
      o_mem_re    <= 1'b0;
      o_mem_raddr <= ext_op_pkg::PTR_RESET;
      move_data_r <= 8'h00;
    end
    else
    begin
      o_mem_re <= (q_r == ext_op_pkg::Q2) && first && is_move;
      if (q_r == ext_op_pkg::Q2)
        o_mem_raddr <= ptr_r[ext_op_pkg::STACK_IDX] + {5'h00, ir_r[6:0]};
      if (o_mem_re)
        move_data_r <= i_mem_rdata;
    end

  // store strobe lives in Q4: push in first cycle, move in second
  always_ff @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n)
    begin
      o_mem_we    <= 1'b0;
      o_mem_waddr <= ext_op_pkg::PTR_RESET;
      o_mem_wdata <= 8'h00;
    end
    else
    begin
      o_mem_we <= 1'b0;
      if (q_r == ext_op_pkg::Q3)
      begin
        if (first && op_r == ext_op_pkg::OP_PUSH)
        begin
          o_mem_we    <= 1'b1;
          o_mem_waddr <= ptr_r[ext_op_pkg::STACK_IDX];
          o_mem_wdata <= lit_r;
        end
        else if (state_r == ext_op_pkg::ST_WORD2 && is_move)
        begin
          o_mem_we    <= 1'b1;
          o_mem_wdata <= move_data_r;
          o_mem_waddr <= (op_r == ext_op_pkg::OP_MOVE_ABS) ? ir2_r[11:0] :
                         ptr_r[ext_op_pkg::STACK_IDX] + {5'h00, ir2_r[6:0]};
        end
      end
    end

  // pc loaded in Q1 of the idle cycle, after the pointer write
  always_ff @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n)
    begin
      o_pc_load  <= 1'b0;
      o_push_pc  <= 1'b0;
      o_pc_value <= ext_op_pkg::PC_RESET;
    end
    else
    begin
      o_push_pc <= (q_r == ext_op_pkg::Q3) && first && op_r == ext_op_pkg::OP_CALL_WK;
      o_pc_load <= (q_r == ext_op_pkg::Q4) && first && (is_ret || op_r == ext_op_pkg::OP_CALL_WK);
      if (q_r == ext_op_pkg::Q4)
        o_pc_value <= (op_r == ext_op_pkg::OP_CALL_WK) ?
                      {i_pc_upper_latch, i_pc_high_latch, i_working_register} :
                      i_return_stack_top;
    end

  assign o_use_indexed  = en_r && !i_std_access_bit && (i_std_file_addr <= ext_op_pkg::INDEX_LIMIT);
  assign o_indexed_addr = ptr_r[ext_op_pkg::STACK_IDX] + {4'h0, i_std_file_addr};
  assign o_q_phase      = q_r;
  assign o_stall        = !first;
  assign o_ext_enabled  = en_r;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  sequence s_taken;
    q_r == ext_op_pkg::Q1 && first && i_instr_valid;
  endsequence

  // old pointer taken one cycle back, where ir_r already holds this word
  a_ptr_add_sum: assert property (s_taken ##0 u_dec_if.op == ext_op_pkg::OP_PTR_ADD |-> ##4
    ptr_r[ir_r[7:6]] == $past(ptr_r[ir_r[7:6]], 1) + {6'h00, $past(i_instr_word[5:0], 4)})
    else $error("pointer add result wrong");

  a_ptr_sub_diff: assert property (s_taken ##0 u_dec_if.op == ext_op_pkg::OP_PTR_SUB |-> ##4
    ptr_r[ir_r[7:6]] == $past(ptr_r[ir_r[7:6]], 1) - {6'h00, $past(i_instr_word[5:0], 4)})
    else $error("pointer subtract result wrong");

  a_return_pc_load: assert property (s_taken ##0 (u_dec_if.op == ext_op_pkg::OP_STACK_ADD_RET ||
    u_dec_if.op == ext_op_pkg::OP_STACK_SUB_RET) |-> ##4 (o_pc_load && o_stall &&
    o_pc_value == $past(i_return_stack_top)) ##4 !o_stall)
    else $error("return did not load pc over two cycles");

  a_call_work_target: assert property (s_taken ##0 u_dec_if.op == ext_op_pkg::OP_CALL_WK
    |-> ##3 o_push_pc ##1 (o_pc_load && o_pc_value == {$past(i_pc_upper_latch),
    $past(i_pc_high_latch), $past(i_working_register)}))
    else $error("register call target wrong");

  a_push_store: assert property (s_taken ##0 u_dec_if.op == ext_op_pkg::OP_PUSH |-> ##3
    (o_mem_we && o_mem_waddr == $past(ptr_r[2], 3) && o_mem_wdata == $past(i_instr_word[7:0], 3))
    ##1 (ptr_r[2] == $past(ptr_r[2], 4) - 12'h001))
    else $error("push literal store or decrement wrong");

  a_move_abs_dest: assert property (s_taken ##0 u_dec_if.op == ext_op_pkg::OP_MOVE_ABS |-> ##4
    (q_r == ext_op_pkg::Q1 && o_stall) ##3 (o_mem_we && o_mem_waddr == $past(i_instr_word[11:0], 3))
    ##1 !o_stall)
    else $error("indexed to absolute move wrong");

  a_move_idx_data: assert property (s_taken ##0 u_dec_if.op == ext_op_pkg::OP_MOVE_IDX |-> ##2
    o_mem_re ##5 (o_mem_we && o_mem_wdata == $past(i_mem_rdata, 5)))
    else $error("indexed to indexed move data wrong");

  a_lone_word_nop: assert property (s_taken ##0 i_instr_word[15:12] == ext_op_pkg::OPC_SECOND
    |-> ##1 (op_r == ext_op_pkg::OP_NONE) [*4])
    else $error("lone second word executed");

  a_disabled_quiet: assert property (!en_r |-> u_dec_if.op == ext_op_pkg::OP_NONE &&
    !o_use_indexed && !o_mem_we && !o_pc_load)
    else $error("extended behaviour while disabled");

endmodule : ext_op_exec

// ===== bench/core_side_model.sv
// Purpose: core data memory seen by the executer's read port
// Assumes: read data is wanted in the same cycle as the read strobe
// Notes:   contents are a fixed pattern of the address, never written
module core_side_model
#(
  parameter int AW = 12
)
(
  input  wire logic          i_clock,
  input  wire logic          i_mem_re,
  input  wire logic [AW-1:0] i_mem_raddr,
  output logic [7:0]         o_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] last_r;

  // answer at once; off-read the line flips every cycle so stale data never matches
  always_comb
  begin
    if (i_mem_re)
      o_mem_rdata = i_mem_raddr[7:0] ^ {i_mem_raddr[11:8], i_mem_raddr[11:8]} ^ 8'h3c;
    else
      o_mem_rdata = ~last_r;
  end

  // remember what was last on the line
  always_ff @(posedge i_clock)
    last_r <= o_mem_rdata;
endmodule : core_side_model

// ===== bench/test_extended_op_decode_exec.sv
// Purpose: random and corner runs of the extended-op executer
// Assumes: core side answers reads at once from a fixed pattern
// Notes:   each instruction gets two full cycles, then one idle cycle passes before the next one
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module test_extended_op_decode_exec;
  timeunit 1ns;
  timeprecision 1ns;

  logic             i_clock, i_arst_n, i_ext_enable_cfg, i_instr_valid, i_std_access_bit;
  logic [15:0]      i_instr_word;
  logic [7:0]       i_working_register, i_pc_high_latch, i_std_file_addr, i_mem_rdata;
  logic [4:0]       i_pc_upper_latch;
  logic [20:0]      i_return_stack_top, o_pc_value, pcv;
  logic [1:0]       o_q_phase;
  logic             o_stall, o_ext_enabled, o_mem_re, o_mem_we, o_pc_load, o_push_pc;
  logic             o_use_indexed;
  logic [2:0][11:0] o_indirect_pointer;
  logic [11:0]      o_mem_raddr, o_mem_waddr, o_indexed_addr, waddr, raddr;
  logic [7:0]       o_mem_wdata, wdata;
  logic [11:0]      ptr [3];
  logic [7:0]       hi_tab [8] = '{8'he8, 8'he9, 8'hea, 8'heb, 8'h00, 8'hf3, 8'h12, 8'he8};
  logic [15:0]      w;
  int               failures, n_checks, cyc, seed, we_c, re_c, pcl_c, push_c, stl;

  ext_op_exec DUT
  (
    .i_clock            (i_clock),
    .i_arst_n           (i_arst_n),
    .i_ext_enable_cfg   (i_ext_enable_cfg),
    .i_instr_word       (i_instr_word),
    .i_instr_valid      (i_instr_valid),
    .i_working_register (i_working_register),
    .i_pc_high_latch    (i_pc_high_latch),
    .i_pc_upper_latch   (i_pc_upper_latch),
    .i_return_stack_top (i_return_stack_top),
    .i_mem_rdata        (i_mem_rdata),
    .i_std_access_bit   (i_std_access_bit),
    .i_std_file_addr    (i_std_file_addr),
    .o_q_phase          (o_q_phase),
    .o_stall            (o_stall),
    .o_ext_enabled      (o_ext_enabled),
    .o_indirect_pointer (o_indirect_pointer),
    .o_mem_re           (o_mem_re),
    .o_mem_raddr        (o_mem_raddr),
    .o_mem_we           (o_mem_we),
    .o_mem_waddr        (o_mem_waddr),
    .o_mem_wdata        (o_mem_wdata),
    .o_pc_load          (o_pc_load),
    .o_pc_value         (o_pc_value),
    .o_push_pc          (o_push_pc),
    .o_use_indexed      (o_use_indexed),
    .o_indexed_addr     (o_indexed_addr)
  );

  core_side_model u_core
  (
    .i_clock     (i_clock),
    .i_mem_re    (o_mem_re),
    .i_mem_raddr (o_mem_raddr),
    .o_mem_rdata (i_mem_rdata)
  );

  // 20 MHz clock
  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // hang guard: about 4000 cycles of real work expected
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  function automatic logic [7:0] rom(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h3c;
  endfunction : rom

  // reset with a given strap; strap held steady across release
  task automatic do_reset(input logic en);
    @(posedge i_clock);
    i_arst_n <= 1'b0;
    i_ext_enable_cfg <= en;
    repeat (8) @(posedge i_clock);
    @(negedge i_clock);
    `CHK("reset pointers", 36'h0, o_indirect_pointer)
    `CHK("reset enabled", 1'b1, o_ext_enabled)
    @(posedge i_clock);
    i_arst_n <= 1'b1;
    ptr = '{default: 12'h000};
  endtask : do_reset

  // present w in Q1, w2 in the following Q1, then compare all effects
  task automatic run(input logic [15:0] w, input logic [15:0] w2);
    logic [11:0] sp, e_wa, e_ra;
    logic [7:0]  hi, fa, e_wd;
    logic [20:0] e_pc;
    logic        en;
    int          lim, idx, e_we, e_re, e_pcl, e_push, e_stl;
    hi = w[15:8];
    en = i_ext_enable_cfg;
    lim = 0;
    @(negedge i_clock);
    while (o_q_phase !== ext_op_pkg::Q4 && lim < 8)
    begin
      @(negedge i_clock);
      lim++;
    end
    `CHK("q phase", ext_op_pkg::Q4, o_q_phase)
    fa = 8'($random(seed));
    if (fa[1:0] == 2'h0)
      fa = 8'h5f;
    if (fa[1:0] == 2'h1)
      fa = 8'h60;
    @(posedge i_clock);
    i_instr_word <= w;
    i_instr_valid <= 1'b1;
    i_working_register <= 8'($random(seed));
    i_pc_high_latch <= 8'($random(seed));
    i_pc_upper_latch <= 5'($random(seed));
    i_return_stack_top <= 21'($random(seed));
    i_std_access_bit <= 1'($random(seed));
    i_std_file_addr <= fa;
    we_c = -1;
    re_c = -1;
    pcl_c = -1;
    push_c = -1;
    stl = 0;
    for (int i = 0; i < 8; i++)
    begin
      if (i > 0)
        @(posedge i_clock);
      if (i == 1)
        i_instr_valid <= 1'b0;
      if (i == 1 || i == 5)
        i_instr_word <= 16'($random(seed));
      if (i == 4)
        i_instr_word <= w2;
      @(negedge i_clock);
      if (i == 0)
      begin
        `CHK("strap", en, o_ext_enabled)
        `CHK("use_indexed", en & ~fa[7] & (fa <= 8'h5f) & ~i_std_access_bit, o_use_indexed)
        // address is formed whatever the access bit says
        `CHK("indexed_addr", ptr[2] + {4'h0, fa}, o_indexed_addr)
      end
      stl += (o_stall === 1'b1);
      if (o_mem_re === 1'b1)
      begin
        re_c = i;
        raddr = o_mem_raddr;
      end
      if (o_mem_we === 1'b1)
      begin
        we_c = i;
        waddr = o_mem_waddr;
        wdata = o_mem_wdata;
      end
      if (o_pc_load === 1'b1)
      begin
        pcl_c = i;
        pcv = o_pc_value;
      end
      if (o_push_pc === 1'b1)
        push_c = i;
    end
    // expected effects worked out from both words, the strap and the model pointers
    sp = ptr[2];
    idx = (w[7:6] == ext_op_pkg::SEL_STACK) ? 2 : int'(w[7:6]);
    {e_we, e_re, e_pcl, e_push, e_stl} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1, 32'sd0};
    e_pc = i_return_stack_top;
    if (en && (hi == ext_op_pkg::OPC_PTR_ADD || hi == ext_op_pkg::OPC_PTR_SUB))
    begin
      ptr[idx] = (hi == ext_op_pkg::OPC_PTR_ADD) ? ptr[idx] + w[5:0] : ptr[idx] - w[5:0];
      e_pcl = (idx == 2 && w[7:6] == 2'h3) ? 4 : -1;
      e_stl = (e_pcl == 4) ? 4 : 0;
    end
    if (en && hi == ext_op_pkg::OPC_PUSH)
    begin
      {e_we, e_wa, e_wd} = {32'sd3, sp, w[7:0]};
      ptr[2] = sp - 12'h001;
    end
    if (en && w == ext_op_pkg::OPC_CALL_WK)
    begin
      {e_push, e_pcl, e_stl} = {32'sd3, 32'sd4, 32'sd4};
      e_pc = {i_pc_upper_latch, i_pc_high_latch, i_working_register};
    end
    if (en && hi == ext_op_pkg::OPC_MOVE)
    begin
      e_ra = sp + w[6:0];
      {e_re, e_we, e_stl, e_wd} = {32'sd2, 32'sd7, 32'sd4, rom(e_ra)};
      e_wa = w[7] ? sp + w2[6:0] : w2[11:0];
    end
    `CHK("mem_re cycle", e_re, re_c)
    `CHK("mem_we cycle", e_we, we_c)
    `CHK("pc_load cycle", e_pcl, pcl_c)
    `CHK("push_pc cycle", e_push, push_c)
    `CHK("stall cycles", e_stl, stl)
    if (e_re >= 0)
      `CHK("mem_raddr", e_ra, raddr)
    if (e_we >= 0)
      `CHK("mem_waddr", e_wa, waddr)
    if (e_we >= 0)
      `CHK("mem_wdata", e_wd, wdata)
    if (e_pcl >= 0)
      `CHK("pc_value", e_pc, pcv)
    for (int j = 0; j < 3; j++)
      `CHK("pointer", ptr[j], o_indirect_pointer[j])
  endtask : run

  // corners, then random traffic, then the same with the extension off
  initial
  begin
    {seed, failures, n_checks, cyc} = {32'sd2, 32'sd0, 32'sd0, 32'sd0};
    i_arst_n <= 1'b0;
    i_ext_enable_cfg <= 1'b1;
    i_instr_word <= 16'h0000;
    i_instr_valid <= 1'b0;
    i_working_register <= 8'h00;
    i_pc_high_latch <= 8'h00;
    i_pc_upper_latch <= 5'h00;
    i_return_stack_top <= 21'h000000;
    i_std_access_bit <= 1'b0;
    i_std_file_addr <= 8'h00;
    for (int pass = 0; pass < 2; pass++)
    begin
      do_reset(pass == 0);
      run(16'he83f, 16'h0000);
      run(16'he97f, 16'h0000);
      run(16'hea5a, 16'h0000);
      run(16'he8ff, 16'h0000);
      run(16'he9c1, 16'h0000);
      run(16'h0014, 16'h0000);
      run(16'heb05, 16'hf123);
      run(16'heb85, 16'hff85);
      run(16'hf0aa, 16'h0000);
      for (int n = 0; n < 150; n++)
      begin
        w = 16'($random(seed));
        w[15:8] = hi_tab[w[2:0] ^ w[10:8]];
        if (w[15:8] == 8'h00)
          w = ext_op_pkg::OPC_CALL_WK;
        run(w, {4'hf, 12'($random(seed))});
      end
    end
    tally_and_finish();
  end
endmodule : test_extended_op_decode_exec
